// ---- core/udma_burst_engine.sv ----
`timescale 1ns/100ps
// Operation
// - Late device ready still takes three strobes
// - Receiver drops ready soon after strobe edge
// - Sender stops strobing shortly after ready drops
// - Fifty ns from last strobe to termination
// - Drive strobe or ready only after acknowledge
// - Pull pin high briefly, then release
// - Each strobe edge carries one word
// - Receiver ready shows room; negation pauses
module udma_burst_engine
  import udma_pkg::*;
#(
  parameter int WR_DEPTH = 8,
  parameter int RD_DEPTH = 2
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Burst control
  input  wire logic [MODE_W-1:0] i_mode,
  input  wire logic              i_start_read,
  input  wire logic              i_start_write,
  input  wire logic              i_dev_stop,
  output logic                   o_busy,
  // Read words toward the host
  input  wire logic              i_rd_valid,
  input  wire logic [WORD_W-1:0] i_rd_data,
  output logic                   o_rd_ready,
  // Write words from the host
  output logic                   o_wr_valid,
  output logic [WORD_W-1:0]      o_wr_data,
  input  wire logic              i_wr_ready,
  // Host pins
  output logic                   o_dma_request,
  input  wire logic              i_dma_acknowledge_n,
  input  wire logic              i_stop,
  input  wire logic              i_host_receive_ready_n,
  input  wire logic              i_host_data_strobe,
  output logic                   o_strobe_ready,
  output logic                   o_strobe_ready_oe,
  input  wire logic [WORD_W-1:0] i_dd,
  output logic [WORD_W-1:0]      o_dd,
  output logic                   o_dd_oe
);
  localparam int WLW         = $clog2(WR_DEPTH + 1);
  localparam int READY_LIMIT = WR_DEPTH - EXTRA_STROBES - PIPE_STROBES;
  localparam int SR_BOUND    = SR_FAST_CYC - SYNC_LAG;

  logic [3:0]        meta_r;
  logic [3:0]        sync_r;
  logic              strb_q_r;
  logic [WORD_W-1:0] dd_meta_r;
  logic [WORD_W-1:0] dd_sync_r;
  logic [WORD_W-1:0] dd_q_r;
  logic              ack_n_s;
  logic              ack;
  logic              stop_s;
  logic              host_rdy;
  logic              hedge;
  logic              host_term;
  logic              ready_ok;
  logic              rd_pop;
  logic              wr_push;
  logic [WLW-1:0]    wr_level;

  state_t            state_r, state_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [CNT_W-1:0]  since_r, since_nxt;
  logic              moved_r, moved_nxt;
  logic              dir_rd_r, dir_rd_nxt;
  logic              pin_r, pin_nxt;
  logic              pin_oe_r, pin_oe_nxt;
  logic [WORD_W-1:0] dd_r, dd_nxt;
  logic              dd_oe_r, dd_oe_nxt;
  logic              dma_request_r, dma_request_nxt;

  stream_if #(.W(WORD_W)) rd_in ();
  stream_if #(.W(WORD_W)) rd_out ();
  stream_if #(.W(WORD_W)) wr_in ();
  stream_if #(.W(WORD_W)) wr_out ();

  // Two-entry buffer: a host pause backs up into the word source
  stream_fifo #(.DEPTH(RD_DEPTH), .W(WORD_W)) u_rd_buf (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .s_in    (rd_in),
    .s_out   (rd_out),
    .o_level ()
  );

  // Landing store sized to absorb the strobes after ready drops
  stream_fifo #(.DEPTH(WR_DEPTH), .W(WORD_W), .LW(WLW)) u_wr_buf (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .s_in    (wr_in),
    .s_out   (wr_out),
    .o_level (wr_level)
  );

  // User side of the buffers
  assign rd_in.valid  = i_rd_valid;
  assign rd_in.data   = i_rd_data;
  assign o_rd_ready   = rd_in.ready;
  assign rd_out.ready = rd_pop;
  assign wr_in.valid  = wr_push;
  assign wr_in.data   = dd_q_r;
  assign o_wr_valid   = wr_out.valid;
  assign o_wr_data    = wr_out.data;
  assign wr_out.ready = i_wr_ready;

  // Pin synchronisers; data rides one stage behind so it predates the edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r    <= SYNC_RST;
      sync_r    <= SYNC_RST;
      strb_q_r  <= 1'b0;
      dd_meta_r <= '0;
      dd_sync_r <= '0;
      dd_q_r    <= '0;
    end else begin
      meta_r    <= {i_host_data_strobe, i_host_receive_ready_n, i_stop, i_dma_acknowledge_n};
      sync_r    <= meta_r;
      strb_q_r  <= sync_r[3];
      dd_meta_r <= i_dd;
      dd_sync_r <= dd_meta_r;
      dd_q_r    <= dd_sync_r;
    end
  end

  // Decoded link conditions; room test uses the edge so the sequencer has no comb loop
  assign ack_n_s   = sync_r[0];
  assign ack       = !ack_n_s;
  assign stop_s    = sync_r[1];
  assign host_rdy  = !sync_r[2];
  assign hedge     = sync_r[3] ^ strb_q_r;
  assign host_term = stop_s && moved_r;
  assign ready_ok  = (int'(wr_level) + int'(hedge)) < READY_LIMIT;

  // Burst sequencing
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    since_nxt  = (since_r == '1) ? since_r : since_r + 1'b1;
    moved_nxt  = moved_r;
    dir_rd_nxt = dir_rd_r;
    pin_nxt    = pin_r;
    pin_oe_nxt = pin_oe_r;
    dd_nxt     = dd_r;
    dd_oe_nxt  = dd_oe_r;
    dma_request_nxt  = dma_request_r;
    rd_pop     = 1'b0;
    wr_push    = 1'b0;
    case (state_r)
      S_IDLE: begin
        moved_nxt = 1'b0;
        if (i_start_read || i_start_write) begin
          dir_rd_nxt = i_start_read;
          dma_request_nxt  = 1'b1;
          state_nxt  = S_REQ;
        end
      end
      S_REQ: begin
        if (ack) begin
          pin_oe_nxt = 1'b1;
          pin_nxt    = 1'b1;
          cnt_nxt    = '0;
          dd_oe_nxt  = dir_rd_r;
          state_nxt  = dir_rd_r ? S_RD_HOLD : S_WR;
        end
      end
      S_RD_HOLD: begin
        if (host_term) begin
          dma_request_nxt = 1'b0;
          state_nxt = S_END;
        end else if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (i_dev_stop) begin
          state_nxt = S_TERM_WAIT;
        end else if (rd_out.valid) begin
          rd_pop    = 1'b1;
          dd_nxt    = rd_out.data;
          cnt_nxt   = cyc_cnt(i_mode);
          state_nxt = S_RD_SETUP;
        end
      end
      S_RD_SETUP: begin
        // The word popped in hold is dropped if the host ends the burst here
        if (host_term) begin
          dma_request_nxt = 1'b0;
          state_nxt = S_END;
        end else if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (host_rdy && !stop_s) begin
          pin_nxt   = !pin_r;
          moved_nxt = 1'b1;
          since_nxt = '0;
          cnt_nxt   = CNT_W'(HOLD_CYC);
          state_nxt = S_RD_HOLD;
        end
      end
      S_WR: begin
        pin_nxt = !ready_ok;
        if (hedge) begin
          wr_push   = 1'b1;
          moved_nxt = 1'b1;
          since_nxt = '0;
        end
        if (host_term) begin
          dma_request_nxt = 1'b0;
          state_nxt = S_END;
        end else if (i_dev_stop) begin
          pin_nxt   = 1'b1;
          state_nxt = S_TERM_WAIT;
        end
      end
      S_TERM_WAIT: begin
        if (!dir_rd_r) begin
          pin_nxt = 1'b1;
          if (hedge) begin
            wr_push   = 1'b1;
            since_nxt = '0;
          end
        end
        if (host_term) begin
          dma_request_nxt = 1'b0;
          state_nxt = S_END;
        end else if (!(hedge && !dir_rd_r) && since_r >= SS_CYC) begin
          dma_request_nxt = 1'b0;
          state_nxt = S_END;
        end
      end
      S_END: begin
        dma_request_nxt = 1'b0;
        if (!dir_rd_r && hedge) begin
          wr_push = 1'b1;
        end
      end
      S_RELEASE: begin
        pin_oe_nxt = 1'b0;
        state_nxt  = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    // Acknowledge gone: drive the pin high for one cycle, then let go
    if (pin_oe_r && !ack && state_r != S_RELEASE) begin
      dma_request_nxt = 1'b0;
      pin_nxt   = 1'b1;
      dd_oe_nxt = 1'b0;
      state_nxt = S_RELEASE;
    end
  end

  // Sequencer registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r  <= S_IDLE;
      cnt_r    <= '0;
      since_r  <= '1;
      moved_r  <= 1'b0;
      dir_rd_r <= 1'b0;
      pin_r    <= 1'b1;
      pin_oe_r <= 1'b0;
      dd_r     <= '0;
      dd_oe_r  <= 1'b0;
      dma_request_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      since_r  <= since_nxt;
      moved_r  <= moved_nxt;
      dir_rd_r <= dir_rd_nxt;
      pin_r    <= pin_nxt;
      pin_oe_r <= pin_oe_nxt;
      dd_r     <= dd_nxt;
      dd_oe_r  <= dd_oe_nxt;
      dma_request_r  <= dma_request_nxt;
    end
  end

  // Pin and status outputs
  assign o_dma_request     = dma_request_r;
  assign o_strobe_ready    = pin_r;
  assign o_strobe_ready_oe = pin_oe_r;
  assign o_dd              = dd_r;
  assign o_dd_oe           = dd_oe_r;
  assign o_busy            = (state_r != S_IDLE);

  // Checking helpers: raw pause length and raw release overlap
  logic [CNT_W-1:0] host_off_r;
  logic [CNT_W-1:0] rel_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      host_off_r <= '0;
      rel_r      <= '0;
    end else begin
      host_off_r <= !i_host_receive_ready_n ? '0 :
                    (host_off_r == '1) ? host_off_r : host_off_r + 1'b1;
      rel_r      <= !(pin_oe_r && i_dma_acknowledge_n) ? '0 :
                    (rel_r == '1) ? rel_r : rel_r + 1'b1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_wr_no_loss:    assert property (wr_push |-> wr_in.ready)
    else $error("write word arrived with no room");
  a_ready_resp:    assert property ((state_r == S_WR && wr_push && !ready_ok)
                     |-> ##[1:SR_BOUND] o_strobe_ready)
    else $error("ready not negated after strobe filled the store");
  a_strobe_window: assert property ((state_r == S_RD_SETUP && pin_nxt != pin_r)
                     |-> host_off_r <= rfs_cnt(i_mode))
    else $error("strobe issued too long after host paused");
  a_term_spacing:  assert property ((state_r == S_TERM_WAIT && dma_request_r && !dma_request_nxt
                     && !host_term && ack) |-> since_r >= SS_CYC)
    else $error("termination too close to last strobe");
  a_drive_ack:     assert property ($rose(o_strobe_ready_oe) |-> !$past(ack_n_s))
    else $error("pin driven before acknowledge");
  a_release_seq:   assert property (($rose(ack_n_s) && pin_oe_r)
                     |=> (o_strobe_ready && o_strobe_ready_oe) ##1 !o_strobe_ready_oe)
    else $error("pin not pulled high then released");
  a_pull_limit:    assert property (rel_r <= PULLUP_CYC)
    else $error("pin driven too long after acknowledge");
  a_wr_capture:    assert property ((hedge && (state_r == S_WR || state_r == S_TERM_WAIT
                     || state_r == S_END) && !dir_rd_r) |-> wr_push)
    else $error("host strobe edge not captured");
  a_rd_hold:       assert property (($changed(o_strobe_ready) && state_r == S_RD_HOLD)
                     |-> $stable(o_dd) [*2])
    else $error("read data moved at strobe edge");
  a_ready_room:    assert property ((state_r == S_WR && !o_strobe_ready)
                     |-> int'(wr_level) < READY_LIMIT)
    else $error("ready asserted without room");

  c_rd_pause: cover property (state_r == S_RD_SETUP && cnt_r == '0 && !host_rdy);
  c_rd_done:  cover property ($fell(o_dma_request) && dir_rd_r);
  c_wr_pause: cover property (state_r == S_WR && $rose(o_strobe_ready));
  c_dev_term: cover property (state_r == S_TERM_WAIT ##1 state_r == S_END);

endmodule

// ---- core/udma_pkg.sv ----
package udma_pkg;

  // Clock and data path
  localparam int CLK_PERIOD_NS = 4;
  localparam int WORD_W        = 16;
  localparam int MODE_W        = 3;
  localparam int NUM_MODES     = 5;
  localparam int CNT_W         = 6;
  localparam int SYNC_LAG      = 2;

  // Per-mode timing, modes 0 to 4, in ns
  localparam int CYC_NS [NUM_MODES] = '{112, 73, 54, 39, 25};
  localparam int RFS_NS [NUM_MODES] = '{75, 70, 60, 60, 60};
  // Strobe to ready limit exists for modes 0 to 2 only
  localparam int SR_MODES           = 3;
  localparam int SR_NS  [SR_MODES]  = '{50, 30, 20};

  // Mode independent timing, in ns
  localparam int SS_NS        = 50;
  localparam int PULLUP_NS    = 20;
  localparam int DATA_HOLD_NS = 6;

  // Flow control slack
  localparam int EXTRA_STROBES = 3;
  localparam int PIPE_STROBES  = 1;

  // Reset of pin synchronisers: ack_n and host ready_n idle high
  localparam logic [3:0] SYNC_RST = 4'h5;

  // Least time, rounded up, never below one cycle
  function automatic int min_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time, rounded down, never below one cycle
  function automatic int max_cyc(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Modes above 4 behave as mode 4
  function automatic int mode_idx(input logic [MODE_W-1:0] m);
    return (int'(m) < NUM_MODES) ? int'(m) : NUM_MODES - 1;
  endfunction

  function automatic logic [CNT_W-1:0] cyc_cnt(input logic [MODE_W-1:0] m);
    return CNT_W'(min_cyc(CYC_NS[mode_idx(m)]));
  endfunction

  function automatic logic [CNT_W-1:0] rfs_cnt(input logic [MODE_W-1:0] m);
    return CNT_W'(max_cyc(RFS_NS[mode_idx(m)]));
  endfunction

  localparam int SS_CYC      = min_cyc(SS_NS);
  localparam int PULLUP_CYC  = max_cyc(PULLUP_NS);
  localparam int HOLD_CYC    = min_cyc(DATA_HOLD_NS);
  localparam int SR_FAST_CYC = max_cyc(SR_NS[SR_MODES-1]);

  typedef enum logic [2:0] {
    S_IDLE, S_REQ, S_RD_HOLD, S_RD_SETUP, S_WR, S_TERM_WAIT, S_END, S_RELEASE
  } state_t;

endpackage

// ---- core/stream_if.sv ----
`timescale 1ns/100ps
interface stream_if #(parameter int W = 16) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- core/stream_fifo.sv ----
`timescale 1ns/100ps
module stream_fifo #(
  parameter int DEPTH = 2,
  parameter int W     = 16,
  parameter int LW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic     i_clk,
  input  wire logic     i_rst_n,
  // Fill and drain sides
  stream_if.snk         s_in,
  stream_if.src         s_out,
  // Occupancy
  output logic [LW-1:0] o_level
);
  localparam int            PW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [LW-1:0] FULL = LW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [W-1:0]  mem_r   [DEPTH];
  logic [W-1:0]  mem_nxt [DEPTH];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] wr_nxt;
  logic [PW-1:0] rd_r;
  logic [PW-1:0] rd_nxt;
  logic [LW-1:0] cnt_r;
  logic [LW-1:0] cnt_nxt;
  logic          push;
  logic          pop;

  // Flags straight from occupancy, so full and empty never lie
  assign s_in.ready  = (cnt_r != FULL);
  assign s_out.valid = (cnt_r != '0);
  assign s_out.data  = mem_r[rd_r];
  assign o_level     = cnt_r;
  assign push        = s_in.valid && s_in.ready;
  assign pop         = s_out.valid && s_out.ready;

  // Pointer and storage update
  always_comb begin
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    if (push) begin
      mem_nxt[wr_r] = s_in.data;
      wr_nxt        = (wr_r == LAST) ? '0 : wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = (rd_r == LAST) ? '0 : rd_r + 1'b1;
    end
    cnt_nxt = cnt_r + LW'(push) - LW'(pop);
  end

  // State registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// ---- sim/host_model.sv ----
`timescale 1ns/100ps
module host_model
  import udma_pkg::*;
(
  // Clock
  input  wire logic              i_clk,
  // Device pins
  input  wire logic              i_dma_request,
  input  wire logic              i_pin,
  input  wire logic              i_pin_oe,
  input  wire logic [WORD_W-1:0] i_dd,
  // Host pins
  output logic                   o_ack_n,
  output logic                   o_stop,
  output logic                   o_rdy_n,
  output logic                   o_strobe,
  output logic [WORD_W-1:0]      o_dd
);
  logic [WORD_W-1:0] got [$];
  int                cyc;
  int                last_e;
  int                resp;
  logic              rel_ok;
  logic              oe_early;

  initial begin
    o_ack_n  = 1'b1;
    o_stop   = 1'b0;
    o_rdy_n  = 1'b1;
    o_strobe = 1'b0;
    o_dd     = 16'h0000;
    cyc      = 0;
    last_e   = 0;
  end

  // Cycle count; idle bus pattern flips so a stale word never matches
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_ack_n) o_dd <= ~o_dd;
  end

  // Wait for request, stop held over the acknowledge setup
  task automatic open_burst();
    for (int t = 0; t < 50 && !i_dma_request; t++) @(posedge i_clk);
    o_stop <= 1'b1;
    repeat (6) @(posedge i_clk);
    oe_early = i_pin_oe;
    o_ack_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_stop <= 1'b0;
  endtask

  // Stop after spacing, release, and note pin level in the last driven cycle
  task automatic close_burst(input logic stop_it);
    int   t;
    logic lp;
    lp = 1'b0;
    if (stop_it) begin
      while (cyc - last_e < 14) @(posedge i_clk);
      o_stop <= 1'b1;
    end
    for (t = 0; t < 100 && i_dma_request; t++) @(posedge i_clk);
    o_ack_n <= 1'b1;
    for (t = 0; t < 8 && i_pin_oe; t++) begin
      lp = i_pin;
      @(posedge i_clk);
    end
    rel_ok = lp && !i_pin_oe && t <= 5;
    repeat (6) @(posedge i_clk);
  endtask

  // Read: take a word on every pin edge, pause once at pause_at words
  task automatic read_burst(input int n, input int pause_at, output int late, output int gmin);
    int   t0;
    logic lastp;
    got.delete();
    late  = 0;
    gmin  = 1000;
    t0    = 0;
    lastp = 1'b1;
    open_burst();
    o_rdy_n <= 1'b0;
    for (int t = 0; t < 5000 && got.size() < n; t++) begin
      @(posedge i_clk);
      if (i_pin_oe && i_pin !== lastp) begin
        got.push_back(i_dd);
        if (got.size() > 1 && cyc - last_e < gmin) gmin = cyc - last_e;
        if (o_rdy_n) late = cyc - t0;
        last_e = cyc;
      end
      lastp = i_pin;
      if (got.size() == pause_at && t0 == 0) begin
        o_rdy_n <= 1'b1;
        t0 = cyc;
      end
      if (t0 != 0 && cyc - t0 == 60) o_rdy_n <= 1'b0;
    end
    close_burst(1'b1);
    o_rdy_n <= 1'b1;
  endtask

  // Write: strobe only while the pin says ready, link period 40 ns
  task automatic write_burst(input int n, input logic [WORD_W-1:0] base,
                             output int sent, output int ss);
    logic pp;
    pp   = 1'b1;
    sent = 0;
    resp = 0;
    open_burst();
    for (int w = 0; w < 4000 && sent < n && i_dma_request; w++) begin
      @(posedge i_clk);
      if (i_pin && !pp && sent > 0 && resp == 0) resp = cyc - last_e;
      pp = i_pin;
      if (i_pin_oe && !i_pin && cyc - last_e >= 9) begin
        o_dd <= base + WORD_W'(sent);
        @(posedge i_clk);
        last_e = cyc;
        o_strobe <= ~o_strobe;
        sent++;
      end
    end
    ss = i_dma_request ? 0 : cyc - last_e;
    close_burst(i_dma_request);
  endtask
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb;
  import udma_pkg::*;

  logic              clk = 1'b0;
  logic              rst_n;
  logic [MODE_W-1:0] mode;
  logic              start_rd;
  logic              start_wr;
  logic              dev_stop;
  logic              busy;
  logic              rd_valid;
  logic [WORD_W-1:0] rd_data;
  logic              rd_ready;
  logic              wr_valid;
  logic [WORD_W-1:0] wr_data;
  logic              wr_ready;
  logic              dma_request;
  logic              ack_n;
  logic              stop;
  logic              hrdy_n;
  logic              hstb;
  logic              pin;
  logic              pin_oe;
  logic [WORD_W-1:0] dd_h;
  logic [WORD_W-1:0] dd_d;
  logic              dd_oe;
  logic [WORD_W-1:0] dd_bus;
  logic [WORD_W-1:0] wq [$];
  int                failures = 0;
  int                checks_done = 0;
  int                cycles = 0;

  // Shared data bus
  assign dd_bus = dd_oe ? dd_d : dd_h;

  always #2 clk = ~clk;

  udma_burst_engine u_udma_burst_engine (
    .i_clk(clk), .i_rst_n(rst_n), .i_mode(mode), .i_start_read(start_rd),
    .i_start_write(start_wr), .i_dev_stop(dev_stop), .o_busy(busy),
    .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_rd_ready(rd_ready),
    .o_wr_valid(wr_valid), .o_wr_data(wr_data), .i_wr_ready(wr_ready),
    .o_dma_request(dma_request), .i_dma_acknowledge_n(ack_n), .i_stop(stop),
    .i_host_receive_ready_n(hrdy_n), .i_host_data_strobe(hstb),
    .o_strobe_ready(pin), .o_strobe_ready_oe(pin_oe), .i_dd(dd_bus),
    .o_dd(dd_d), .o_dd_oe(dd_oe)
  );

  host_model u_host_model (
    .i_clk(clk), .i_dma_request(dma_request), .i_pin(pin), .i_pin_oe(pin_oe), .i_dd(dd_bus),
    .o_ack_n(ack_n), .o_stop(stop), .o_rdy_n(hrdy_n), .o_strobe(hstb), .o_dd(dd_h)
  );

  // Drained write words; sampled at the handshake edge
  always @(posedge clk) begin
    if (wr_valid && wr_ready) wq.push_back(wr_data);
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Fill the read buffer; blocks whenever it refuses
  task automatic push(input int n, input logic [WORD_W-1:0] base);
    for (int i = 0; i < n; i++) begin
      rd_valid <= 1'b1;
      rd_data  <= base + WORD_W'(i);
      @(posedge clk);
      while (!rd_ready) @(posedge clk);
    end
    rd_valid <= 1'b0;
  endtask

  task automatic idle_wait();
    for (int i = 0; i < 300 && busy; i++) @(posedge clk);
    check("busy", busy, 1'b0);
  endtask

  // Pins quiet during and right after reset
  task automatic t_reset();
    repeat (5) @(posedge clk);
    check("rst", {dma_request, pin, pin_oe, dd_oe, busy, rd_ready, wr_valid}, 7'h22);
    rst_n <= 1'b1;
    @(posedge clk);
    check("rel", {dma_request, pin, pin_oe, dd_oe, busy, rd_ready, wr_valid}, 7'h22);
  endtask

  // Read burst, optional host pause, host or device termination
  task automatic t_read(input int m, input int pause_at, input logic dterm);
    int                late;
    int                gmin;
    logic [WORD_W-1:0] base;
    base = WORD_W'(m * 256) + 16'h00a5;
    mode     <= MODE_W'(m);
    start_rd <= 1'b1;
    @(posedge clk);
    start_rd <= 1'b0;
    fork
      push(6, base);
      u_host_model.read_burst(6, pause_at, late, gmin);
      if (dterm) begin
        // Stop only once the last word is on the host side
        do @(posedge clk); while (u_host_model.got.size() < 6);
        dev_stop <= 1'b1;
      end
    join
    for (int i = 0; i < 6; i++) check("rd_word", u_host_model.got[i], base + WORD_W'(i));
    check("rd_gap", gmin * CLK_PERIOD_NS >= CYC_NS[m], 1);
    check("rd_rfs", late <= RFS_NS[m] / CLK_PERIOD_NS + 1, 1);
    check("rd_rel", u_host_model.rel_ok, 1'b1);
    check("rd_oe", u_host_model.oe_early, 1'b0);
    idle_wait();
    dev_stop <= 1'b0;
  endtask

  // Write burst against a stalled store, then drain; optional device stop
  task automatic t_write(input int m, input logic dterm);
    int                sent;
    int                ss;
    logic [WORD_W-1:0] base;
    base = 16'h5a00 + WORD_W'(m);
    wq.delete();
    mode     <= MODE_W'(m);
    wr_ready <= 1'b0;
    start_wr <= 1'b1;
    @(posedge clk);
    start_wr <= 1'b0;
    fork
      u_host_model.write_burst(12, base, sent, ss);
      begin
        repeat (100) @(posedge clk);
        wr_ready <= 1'b1;
        repeat (30) @(posedge clk);
        dev_stop <= dterm;
      end
    join
    idle_wait();
    dev_stop <= 1'b0;
    repeat (20) @(posedge clk);
    check("wr_count", wq.size(), sent);
    for (int i = 0; i < sent; i++) check("wr_word", wq[i], base + WORD_W'(i));
    check("wr_pause", u_host_model.resp > 0 && u_host_model.resp <= 5, 1);
    if (dterm) check("wr_ss", ss * CLK_PERIOD_NS >= SS_NS, 1);
    check("wr_rel", u_host_model.rel_ok, 1'b1);
    check("wr_oe", u_host_model.oe_early, 1'b0);
  endtask

  initial begin
    rst_n    = 1'b0;
    mode     = '0;
    start_rd = 1'b0;
    start_wr = 1'b0;
    dev_stop = 1'b0;
    rd_valid = 1'b0;
    rd_data  = '0;
    wr_ready = 1'b0;
    t_reset();
    for (int m = 0; m < NUM_MODES; m++) t_read(m, (m % 2 == 0) ? 3 : 99, m == 1);
    t_write(0, 1'b0);
    t_write(2, 1'b1);
    t_write(4, 1'b0);
    wrap_up();
  end
endmodule
